// >>> tb/reset_status_and_system_options_test.sv
// Self-checking testbench for the reset status and options block.
`timescale 1ns/1ns
module reset_status_and_system_options_test;
   import rsso_pkg::*;
   logic       clk, rst_b, wr, rd, dbg, pin_b, lvt, lve, wde, ila, exi, exs, exb, bme, cks;
   logic       sysrst, restart, ubc, grant, two, s, gseen;
   logic [1:0] addr, tmo;
   logic [7:0] wdata, rdata;
   int         err_count = 0;
   int         n_compared = 0;
   logic [7:0] exp_sts [7] = '{8'h82, 8'h40, 8'h08, 8'h10, 8'h10, 8'h10, 8'h20};

   // Clock of 8 ns period; grant pulses are latched for later checks.
   initial clk = 1'b0;
   always #4 clk = ~clk;
   always @(posedge clk) if (grant === 1'b1) gseen <= 1'b1;

   rsso_core #(.HOLD_CYCLES(2)) u_rsso_core (.clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_from_debug_i(dbg), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .pin_reset_b_i(pin_b), .low_voltage_trip_i(lvt),
      .low_voltage_reset_enable_i(lve), .watchdog_expired_i(wde), .illegal_address_i(ila),
      .exec_illegal_i(exi), .exec_stop_i(exs), .exec_background_i(exb),
      .background_mode_enable_i(bme), .watchdog_clock_select_i(cks),
      .system_reset_o(sysrst), .watchdog_restart_o(restart),
      .watchdog_timeout_select_o(tmo), .watchdog_use_bus_clock_o(ubc),
      .stop_grant_o(grant), .two_wire_pin_select_o(two));
   rsso_host u_rsso_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .dbg_o(dbg), .wdata_o(wdata));

   // Compares one value and counts the outcome.
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   // Reads a register and compares it.
   task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string name);
      logic [7:0] d;
      u_rsso_host.rd(a, d);
      chk(name, exp, d);
   endtask

   // Raises one reset source for a single cycle.
   task automatic hit(input int k);
      @(posedge clk);
      #1;
      case (k)
         0: {lve, lvt} = 2'b11;
         1: pin_b = 1'b0;
         2: ila = 1'b1;
         3: exi = 1'b1;
         4: exs = 1'b1;
         5: exb = 1'b1;
         default: wde = 1'b1;
      endcase
      @(posedge clk);
      #1;
      {lve, lvt, ila, exi, exs, exb, wde} = 7'h0;
      pin_b = 1'b1;
   endtask

   // Tells whether a reset started, waiting a bounded time for it to end.
   task automatic run_out;
      s = 1'b0;
      for (int i = 0; i < 40 && !(s && sysrst === 1'b0); i++) begin
         @(posedge clk);
         #1;
         if (sysrst === 1'b1) s = 1'b1;
      end
   endtask

   // Service pair gives one restart pulse and keeps the power-on flags.
   task automatic t_svc;
      u_rsso_host.wr(RSSO_IDX_STATUS, RSSO_SVC_FIRST, 1'b0, 2);
      chk("restart", 8'h01, {7'h0, restart});
      @(posedge clk);
      #1;
      chk("restart end", 8'h00, {7'h0, restart});
      rdchk(RSSO_IDX_STATUS, 8'h82, "status kept");
      rdchk(RSSO_IDX_DBG, 8'h00, "debug read");
      rdchk(RSSO_IDX_OPT1, RSSO_OPT1_RESET, "options reset");
      rdchk(2'h3, 8'h00, "unmapped read");
   endtask

   // Each source in turn, then both kinds of debug register write.
   task automatic t_srcs;
      for (int k = 0; k < 7; k++) begin
         hit(k);
         run_out();
         chk("reset entry", 8'h01, {7'h0, s});
         rdchk(RSSO_IDX_STATUS, exp_sts[k], "captured status");
      end
      u_rsso_host.wr(RSSO_IDX_DBG, 8'h01, 1'b0, 1);
      run_out();
      chk("user debug write", 8'h00, {7'h0, s});
      u_rsso_host.wr(RSSO_IDX_DBG, 8'h01, 1'b1, 1);
      run_out();
      chk("forced reset", 8'h01, {7'h0, s});
      rdchk(RSSO_IDX_STATUS, 8'h00, "forced status");
      u_rsso_host.wr(RSSO_IDX_STATUS, 8'h12, 1'b0, 1);
      run_out();
      rdchk(RSSO_IDX_STATUS, 8'h20, "bad write status");
   endtask

   // One options write takes; watchdog off, stop and background legal.
   task automatic t_opt;
      cks = 1'b1;
      u_rsso_host.wr(RSSO_IDX_OPT1, 8'h37, 1'b0, 1);
      rdchk(RSSO_IDX_OPT1, 8'h34, "options");
      chk("timeout select", 8'h00, {6'h0, tmo});
      chk("pin select", 8'h01, {7'h0, two});
      chk("bus clock", 8'h01, {7'h0, ubc});
      u_rsso_host.wr(RSSO_IDX_OPT1, 8'hc0, 1'b0, 1);
      rdchk(RSSO_IDX_OPT1, 8'h34, "options locked");
      u_rsso_host.wr(RSSO_IDX_STATUS, 8'h12, 1'b0, 1);
      run_out();
      chk("bad write off", 8'h00, {7'h0, s});
      bme = 1'b1;
      gseen = 1'b0;
      hit(6);
      hit(5);
      hit(4);
      run_out();
      chk("quiet sources", 8'h00, {7'h0, s});
      chk("stop grant", 8'h01, {7'h0, gseen});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Main sequence after a ten-cycle reset.
   initial begin
      rst_b = 1'b0;
      pin_b = 1'b1;
      gseen = 1'b0;
      {lvt, lve, wde, ila, exi, exs, exb, bme, cks} = 9'h0;
      repeat (10) @(posedge clk);
      #1;
      rst_b = 1'b1;
      run_out();
      t_svc();
      t_srcs();
      t_opt();
      finish_test();
   end

   // The tests need well under 1500 cycles; this cuts a hang short.
   initial begin
      #20000;
      err_count++;
      finish_test();
   end
endmodule // reset_status_and_system_options_test

// >>> tb/rsso_checker.sv
// Concurrent checks on the ports of the reset status and options block.
`timescale 1ns/1ns
module rsso_checker
   import rsso_pkg::*;
(
   // Clock, reset and register port
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic       reg_from_debug_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Reset sources
   input wire logic       pin_reset_b_i,
   input wire logic       low_voltage_trip_i,
   input wire logic       low_voltage_reset_enable_i,
   input wire logic       watchdog_expired_i,
   input wire logic       illegal_address_i,
   input wire logic       exec_illegal_i,
   input wire logic       exec_stop_i,
   input wire logic       exec_background_i,
   // Outputs
   input wire logic       system_reset_o,
   input wire logic       watchdog_restart_o,
   input wire logic [1:0] watchdog_timeout_select_o,
   input wire logic       stop_grant_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // No reset source input is active; register-port writes are not included.
   wire quiet = pin_reset_b_i & ~(low_voltage_trip_i & low_voltage_reset_enable_i)
      & ~illegal_address_i & ~exec_illegal_i & ~exec_stop_i & ~exec_background_i
      & ~watchdog_expired_i;
   wire run = ~system_reset_o;
   wire st_wr = reg_wr_i & (reg_addr_i == RSSO_IDX_STATUS) & run;
   wire odd = (reg_wdata_i != RSSO_SVC_FIRST) & (reg_wdata_i != RSSO_SVC_SECOND);

   chk_dbg_read_zero: assert property (reg_rd_i && reg_addr_i == RSSO_IDX_DBG
      |=> reg_rdata_o == RSSO_DBG_READ) else $error("debug read not zero");
   chk_status_gaps: assert property (reg_rd_i && reg_addr_i == RSSO_IDX_STATUS
      |=> reg_rdata_o[2] == 1'b0 && reg_rdata_o[0] == 1'b0) else $error("status gap set");
   chk_svc_restart: assert property (st_wr && reg_wdata_i == RSSO_SVC_FIRST
      ##1 st_wr && reg_wdata_i == RSSO_SVC_SECOND |=> watchdog_restart_o)
      else $error("service pair gave no restart");
   chk_bad_trip: assert property (st_wr && odd && watchdog_timeout_select_o != 2'h0
      |=> $rose(system_reset_o)) else $error("bad status write did not trip");
   chk_tmo_off_quiet: assert property (st_wr && quiet && watchdog_timeout_select_o == 2'h0
      |-> ##1 run) else $error("watchdog off but reset");
   chk_user_dbg_ignored: assert property (reg_wr_i && reg_addr_i == RSSO_IDX_DBG
      && !reg_from_debug_i && run && quiet |=> run) else $error("user debug write reset");
   chk_dbg_force: assert property (reg_wr_i && reg_addr_i == RSSO_IDX_DBG && run
      && reg_from_debug_i && reg_wdata_i[0] |=> system_reset_o) else $error("no forced reset");
   chk_pin_reset: assert property (!pin_reset_b_i && run |=> system_reset_o)
      else $error("pin reset missed");
   chk_illegal_op: assert property (exec_illegal_i && run |=> system_reset_o)
      else $error("illegal opcode reset missed");
   chk_lv_reset: assert property (low_voltage_trip_i && low_voltage_reset_enable_i
      && run |=> system_reset_o) else $error("low voltage reset missed");

   cov_restart: cover property (watchdog_restart_o);
   cov_stop: cover property (stop_grant_o);
   cov_reset: cover property ($fell(system_reset_o));
endmodule // rsso_checker

bind rsso_core rsso_checker u_rsso_checker (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_from_debug_i(reg_from_debug_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .pin_reset_b_i(pin_reset_b_i), .low_voltage_trip_i(low_voltage_trip_i),
   .low_voltage_reset_enable_i(low_voltage_reset_enable_i),
   .watchdog_expired_i(watchdog_expired_i), .illegal_address_i(illegal_address_i),
   .exec_illegal_i(exec_illegal_i), .exec_stop_i(exec_stop_i),
   .exec_background_i(exec_background_i), .system_reset_o(system_reset_o),
   .watchdog_restart_o(watchdog_restart_o),
   .watchdog_timeout_select_o(watchdog_timeout_select_o), .stop_grant_o(stop_grant_o));

// >>> tb/rsso_host.sv
// Register port master standing for the CPU bus and the background debug host.
`timescale 1ns/1ns
module rsso_host (
   // Clock and read data
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   // Register port requests
   output logic      [1:0] addr_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic            dbg_o,
   output logic      [7:0] wdata_o
);
   // The port starts idle with no strobe raised.
   initial begin
      addr_o = 2'h3;
      wdata_o = 8'h00;
      {wr_o, rd_o, dbg_o} = 3'h0;
   end

   // Holds a request for one edge, or two when n > 1; the second edge carries the inverted data.
   task automatic put(input logic [1:0] a, input logic [7:0] d, input logic w,
                      input logic g, input int n);
      @(posedge clk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = w;
      rd_o = ~w;
      dbg_o = g;
      if (n > 1) begin
         @(posedge clk_i);
         #1;
         wdata_o = ~d;
      end
      @(posedge clk_i);
      #1;
      {wr_o, rd_o, dbg_o} = 3'h0;
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
   endtask

   // Writes one byte, or the service pair when n is 2.
   task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic g, input int n);
      put(a, d, 1'b1, g, n);
   endtask

   // Reads one byte once the registered answer has settled.
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      put(a, 8'h00, 1'b0, 1'b0, 1);
      @(posedge clk_i);
      #1;
      d = rdata_i;
   endtask
endmodule // rsso_host

// >>> verilog/rsso_core.sv
// Reset source recording, watchdog service path, debug reset and options.
//
// Behaviour
// - A debug-forced reset leaves every reset source flag cleared.
// - With watchdog on, status writes other than 0x55 or 0xAA trip it.
// - Writing 0x55 then 0xAA restarts the watchdog; flags stay unchanged.
// - Power-on reset sets the power-on flag and the low-voltage flag.
// - Other resets except low-voltage capture active sources and clear power-on and low-voltage flags.
// - Bit 6 records a reset from the low external reset pin.
// - Bit 5 records watchdog timeout; timeout select 0 disables watchdog resets.
// - Illegal opcode resets and sets bit 4; stop/background count when disabled.
// - Access at an unimplemented address resets and sets bit 3.
// - Enabled low-voltage trip resets and sets bit 1.
// - Debug reset register ignores user writes, accepts only debug port writes.
// - The debug reset register always reads 0x00.
// - Writing 1 to the force bit from the debug port resets the device.
// - First options register takes only the first write after reset.
// - Bits 7:6 hold the timeout select, combined with clock select.
// - Bit 5 enables stop; when clear, stop forces an illegal-opcode reset.
// - Bit 2 routes the two-wire bus pins: 0 port A, 1 port B.
// - Bit 4 is reserved: stored, but it drives nothing.
// - Watchdog clock select picks 1 kHz clock at 0, bus clock at 1.
`timescale 1ns/1ns
module rsso_core
   import rsso_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = RSSO_HOLD_CYC,
   parameter int unsigned HOLD_W      = 8
) (
   // Clock and power-on reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Register port
   input  wire logic [1:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic       reg_from_debug_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Reset sources
   input  wire logic       pin_reset_b_i,
   input  wire logic       low_voltage_trip_i,
   input  wire logic       low_voltage_reset_enable_i,
   input  wire logic       watchdog_expired_i,
   input  wire logic       illegal_address_i,
   // Instruction decode inputs
   input  wire logic       exec_illegal_i,
   input  wire logic       exec_stop_i,
   input  wire logic       exec_background_i,
   input  wire logic       background_mode_enable_i,
   // Second options register clock select bit
   input  wire logic       watchdog_clock_select_i,
   // Outputs to the rest of the chip
   output logic            system_reset_o,
   output logic            watchdog_restart_o,
   output logic      [1:0] watchdog_timeout_select_o,
   output logic            watchdog_use_bus_clock_o,
   output logic            stop_grant_o,
   output logic            two_wire_pin_select_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic              rst_sync_b;
   rsso_state_t       state_reg;
   rsso_state_t       state_next;
   rsso_svc_t         svc_reg;
   logic [HOLD_W-1:0] hold_cnt_reg;
   logic [7:0]        status_reg;
   logic [7:0]        opt1_q;
   logic              opt1_locked;
   logic [7:0]        opt1_rdata;
   logic              wdog_enabled;
   logic              wr_status;
   logic              wr_dbg;
   logic              wr_opt1;
   logic              svc_first;
   logic              svc_second;
   logic              bad_write;
   logic              stop_enable;
   logic              badop_now;
   rsso_src_t         src;
   logic              any_src;
   logic              entry;
   logic              hold_done;
   logic              sustain;

   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES - 1);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Decodes a register index; used by every write and read path.
   function automatic logic rsso_hit(input logic [1:0] addr, input logic [1:0] idx);
      rsso_hit = (addr == idx);
   endfunction

   // Builds the status value captured at entry into a reset.
   function automatic logic [7:0] rsso_capture(input rsso_src_t s,
                                               input logic [7:0] cur);
      logic [7:0] v;
      v = 8'h00;
      if (s.lowv) begin
         v[RSSO_STS_POR]  = cur[RSSO_STS_POR];
         v[RSSO_STS_LOWV] = 1'b1;
      end else if (!s.dbg) begin
         v[RSSO_STS_PIN]   = s.pin;
         v[RSSO_STS_WDOG]  = s.wdog;
         v[RSSO_STS_BADOP] = s.badop;
         v[RSSO_STS_BADAD] = s.badad;
      end
      rsso_capture = v;
   endfunction

   // ************************************************************
   // Reset release
   // ************************************************************
   rsso_rst_sync u_rst_sync (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .rst_sync_b_o (rst_sync_b)
   );

   // ************************************************************
   // Register decode
   // ************************************************************

   // Writes are taken only while the device is running.
   assign wr_status = reg_wr_i && (state_reg == RSSO_RUN)
                      && rsso_hit(reg_addr_i, RSSO_IDX_STATUS);
   assign wr_dbg    = reg_wr_i && (state_reg == RSSO_RUN) && reg_from_debug_i
                      && rsso_hit(reg_addr_i, RSSO_IDX_DBG);
   assign wr_opt1   = reg_wr_i && (state_reg == RSSO_RUN)
                      && rsso_hit(reg_addr_i, RSSO_IDX_OPT1);

   // Service values and any other value written to the status address.
   assign svc_first  = wr_status && (reg_wdata_i == RSSO_SVC_FIRST);
   assign svc_second = wr_status && (reg_wdata_i == RSSO_SVC_SECOND);
   assign bad_write  = wr_status && !svc_first && !svc_second;

   // ************************************************************
   // First options register
   // ************************************************************
   rsso_write_once #(
      .WIDTH     (8),
      .RESET_VAL (RSSO_OPT1_RESET)
   ) u_opt1 (
      .clk_i     (clk_i),
      .rst_b_i   (rst_sync_b),
      .clear_i   (entry),
      .wr_i      (wr_opt1),
      .wdata_i   (reg_wdata_i),
      .q_o       (opt1_q),
      .locked_o  (opt1_locked)
   );

   // Field views of the options register; the reserved bit feeds nothing.
   assign opt1_rdata   = opt1_q & RSSO_OPT1_MASK;
   assign stop_enable  = opt1_q[RSSO_OPT_STPEN];
   assign wdog_enabled = opt1_q[RSSO_OPT_TMO_H:RSSO_OPT_TMO_L] != RSSO_TMO_OFF;

   // ************************************************************
   // Reset sources
   // ************************************************************

   // Stop and background count as illegal when their modes are disabled.
   assign badop_now = exec_illegal_i
                     || (exec_stop_i && !stop_enable)
                     || (exec_background_i && !background_mode_enable_i);

   // Collects every source that is active in this cycle.
   always_comb begin
      src      = '0;
      src.lowv = low_voltage_trip_i && low_voltage_reset_enable_i;
      src.dbg  = wr_dbg && reg_wdata_i[RSSO_FORCE_BIT];
      src.pin  = !pin_reset_b_i;
      src.wdog = wdog_enabled && (bad_write || watchdog_expired_i);
      src.badop = badop_now;
      src.badad = illegal_address_i;
   end

   assign any_src = |src;
   assign entry   = (state_reg == RSSO_RUN) && any_src;

   // The pin and the low-voltage detector keep the device held while active.
   assign sustain   = src.pin || src.lowv;
   assign hold_done = (hold_cnt_reg == '0) && !sustain;

   // ************************************************************
   // Reset hold state machine
   // ************************************************************

   // Chooses between running and holding the system in reset.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RSSO_RUN: begin
            if (any_src) begin
               state_next = RSSO_HOLD;
            end
         end
         RSSO_HOLD: begin
            if (hold_done) begin
               state_next = RSSO_RUN;
            end
         end
         default: begin
            state_next = RSSO_HOLD;
         end
      endcase
   end

   // Holds the state; power-on starts in the hold phase.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_reg <= RSSO_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   // Counts the minimum length of the reset and reloads while a level holds it.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         hold_cnt_reg <= HOLD_LOAD;
      end else if (entry || ((state_reg == RSSO_HOLD) && sustain)) begin
         hold_cnt_reg <= HOLD_LOAD;
      end else if ((state_reg == RSSO_HOLD) && (hold_cnt_reg != '0)) begin
         hold_cnt_reg <= hold_cnt_reg - HOLD_W'(1);
      end
   end

   // Drives the system reset from the next state so it is high exactly while state_reg is in the hold phase.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         system_reset_o <= 1'b1;
      end else begin
         system_reset_o <= (state_next == RSSO_HOLD);
      end
   end

   // ************************************************************
   // Reset source status
   // ************************************************************

   // Loads the power-on pattern, then captures sources at each reset entry.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         status_reg <= RSSO_STS_POR_VAL;
      end else if (entry) begin
         status_reg <= rsso_capture(src, status_reg) & RSSO_STS_MASK;
      end
   end

   // ************************************************************
   // Watchdog service
   // ************************************************************

   // Tracks the first half of the service pair; any other status write disarms it.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         svc_reg <= RSSO_SVC_IDLE;
      end else if (entry) begin
         svc_reg <= RSSO_SVC_IDLE;
      end else if (svc_first) begin
         svc_reg <= RSSO_SVC_ARMED;
      end else if (wr_status) begin
         svc_reg <= RSSO_SVC_IDLE;
      end
   end

   // Pulses the restart for one cycle when 0xAA follows 0x55.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         watchdog_restart_o <= 1'b0;
      end else begin
         watchdog_restart_o <= svc_second && (svc_reg == RSSO_SVC_ARMED);
      end
   end

   // Exports the timeout select and the clock choice to the watchdog counter.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         watchdog_timeout_select_o <= RSSO_OPT1_RESET[RSSO_OPT_TMO_H:RSSO_OPT_TMO_L];
         watchdog_use_bus_clock_o  <= 1'b0;
      end else begin
         watchdog_timeout_select_o <= opt1_q[RSSO_OPT_TMO_H:RSSO_OPT_TMO_L];
         watchdog_use_bus_clock_o  <= watchdog_clock_select_i;
      end
   end

   // ************************************************************
   // Option outputs
   // ************************************************************

   // Grants a stop only when stop mode is enabled and no reset is pending.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         stop_grant_o <= 1'b0;
      end else begin
         stop_grant_o <= exec_stop_i && stop_enable && !entry && !any_src;
      end
   end

   // Routes the two-wire bus pin pair.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         two_wire_pin_select_o <= RSSO_OPT1_RESET[RSSO_OPT_TWPIN];
      end else begin
         two_wire_pin_select_o <= opt1_q[RSSO_OPT_TWPIN];
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************

   // Returns the addressed register one cycle after a read; holds otherwise.
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         if (rsso_hit(reg_addr_i, RSSO_IDX_STATUS)) begin
            reg_rdata_o <= status_reg & RSSO_STS_MASK;
         end else if (rsso_hit(reg_addr_i, RSSO_IDX_DBG)) begin
            reg_rdata_o <= RSSO_DBG_READ;
         end else if (rsso_hit(reg_addr_i, RSSO_IDX_OPT1)) begin
            reg_rdata_o <= opt1_rdata;
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

endmodule // rsso_core

// >>> verilog/rsso_pkg.sv
// Package with the constants and types shared by the reset status and options block.
package rsso_pkg;

   // ************************************************************
   // Register indices on the device register port
   // ************************************************************
   localparam logic [1:0] RSSO_IDX_STATUS = 2'h0;
   localparam logic [1:0] RSSO_IDX_DBG    = 2'h1;
   localparam logic [1:0] RSSO_IDX_OPT1   = 2'h2;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned RSSO_STS_POR   = 7;
   localparam int unsigned RSSO_STS_PIN   = 6;
   localparam int unsigned RSSO_STS_WDOG  = 5;
   localparam int unsigned RSSO_STS_BADOP = 4;
   localparam int unsigned RSSO_STS_BADAD = 3;
   localparam int unsigned RSSO_STS_LOWV  = 1;
   localparam int unsigned RSSO_OPT_TMO_H = 7;
   localparam int unsigned RSSO_OPT_TMO_L = 6;
   localparam int unsigned RSSO_OPT_STPEN = 5;
   localparam int unsigned RSSO_OPT_RSV   = 4;
   localparam int unsigned RSSO_OPT_TWPIN = 2;
   localparam int unsigned RSSO_FORCE_BIT = 0;

   // ************************************************************
   // Masks, reset values and special data values
   // ************************************************************
   localparam logic [7:0] RSSO_STS_MASK   = 8'hfa;
   localparam logic [7:0] RSSO_STS_POR_VAL = 8'h82;
   localparam logic [7:0] RSSO_OPT1_MASK  = 8'hf4;
   localparam logic [7:0] RSSO_OPT1_RESET = 8'hc0;
   localparam logic [7:0] RSSO_DBG_READ   = 8'h00;
   localparam logic [7:0] RSSO_SVC_FIRST  = 8'h55;
   localparam logic [7:0] RSSO_SVC_SECOND = 8'haa;
   localparam logic [1:0] RSSO_TMO_OFF    = 2'h0;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned RSSO_CLK_NS    = 8;
   localparam int unsigned RSSO_HOLD_NS   = 256;
   localparam int unsigned RSSO_HOLD_CYC  = (RSSO_HOLD_NS + RSSO_CLK_NS - 1) / RSSO_CLK_NS;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic lowv;
      logic dbg;
      logic pin;
      logic wdog;
      logic badop;
      logic badad;
   } rsso_src_t;

   typedef enum logic [0:0] {
      RSSO_RUN  = 1'b0,
      RSSO_HOLD = 1'b1
   } rsso_state_t;

   typedef enum logic [0:0] {
      RSSO_SVC_IDLE  = 1'b0,
      RSSO_SVC_ARMED = 1'b1
   } rsso_svc_t;

endpackage

// >>> verilog/rsso_rst_sync.sv
// Two-stage synchroniser that releases an asynchronous active-low reset.
`timescale 1ns/1ns
module rsso_rst_sync (
   // Clock and raw reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Released reset
   output logic      rst_sync_b_o
);

   logic stage1_reg;

   // *****************************************************
   // Assert at once, release after two clock edges.
   // *****************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1_reg   <= 1'b0;
         rst_sync_b_o <= 1'b0;
      end else begin
         stage1_reg   <= 1'b1;
         rst_sync_b_o <= stage1_reg;
      end
   end

endmodule // rsso_rst_sync

// >>> verilog/rsso_write_once.sv
// Register that honours only the first write after each reset.
`timescale 1ns/1ns
module rsso_write_once #(
   parameter int unsigned     WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   // Soft clear from a system reset
   input  wire logic             clear_i,
   // Write strobe and data
   input  wire logic             wr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   // Stored value and lock state
   output logic      [WIDTH-1:0] q_o,
   output logic                  locked_o
);

   // *****************************************************
   // The first write stores and locks; later writes are dropped.
   // *****************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q_o      <= RESET_VAL;
         locked_o <= 1'b0;
      end else if (clear_i) begin
         q_o      <= RESET_VAL;
         locked_o <= 1'b0;
      end else if (wr_i && !locked_o) begin
         q_o      <= wdata_i;
         locked_o <= 1'b1;
      end
   end

endmodule // rsso_write_once
